// file: scpi_status_reporting.sv
`include "scpi_status_defs.svh"
module scpi_status_reporting
    import scpi_status_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire cmd_t i_cmd,
    input wire logic i_serial_poll,
    input wire logic [15:0] i_oper_cond,
    input wire logic [15:0] i_ques_cond,
    input wire logic [7:0] i_std_event,
    input wire logic i_err_not_empty,
    input wire logic i_err_entry,
    input wire logic i_msg_avail,
    output rsp_t o_rsp,
    output logic [7:0] o_sbyte,
    output logic o_srq
);
    logic [7:0] service_request_mask;
    logic [7:0] std_event_part;
    logic [7:0] std_enable_mask;
    parts_t oper_parts;
    parts_t ques_parts;
    wire logic oper_sum;
    wire logic ques_sum;
    wire logic esb;
    wire logic take;
    wire logic clr_all;
    wire logic wr_srmask;
    wire logic wr_ese;
    wire logic rd_esr;
    wire logic [7:0] next_esr;
    wire logic [15:0] rd_data;
    wire rsp_t next_rsp;

    // a command is taken only when no serial poll claims the answer port
    function automatic logic hit(input cmd_t c, input logic tk,
                                 input target_t t, input op_t o);
        return tk && (c.target == t) && (c.op == o);
    endfunction

    assign take = i_cmd.valid & ~i_serial_poll;
    // a clear command empties every event part and the standard events
    assign clr_all = take && (i_cmd.op == op_clear);
    assign wr_srmask = hit(i_cmd, take, tgt_srmask, op_write);
    assign wr_ese = hit(i_cmd, take, tgt_ese, op_write);
    assign rd_esr = hit(i_cmd, take, tgt_esr, op_read);

    // standard events: new pulses win over the read clear
    assign next_esr = (rd_esr | clr_all) ? i_std_event : (std_event_part | i_std_event);
    assign esb = |(std_event_part & std_enable_mask);

    // mask and standard event storage
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            service_request_mask <= `SRMASK_RESET;
            std_enable_mask <= `ESE_RESET;
            std_event_part <= 8'h00;
        end else begin
            std_event_part <= next_esr;
            if (wr_srmask) service_request_mask <= i_cmd.data[7:0];
            if (wr_ese) std_enable_mask <= i_cmd.data[7:0];
        end
    end

    // operation register; its summary lands in status byte bit 7
    scpi_status_reg u_oper (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_cond(i_oper_cond),
        .i_wr_rise(hit(i_cmd, take, tgt_op_rise, op_write)),
        .i_wr_fall(hit(i_cmd, take, tgt_op_fall, op_write)),
        .i_wr_enable(hit(i_cmd, take, tgt_op_enable, op_write)),
        .i_wdata(i_cmd.data),
        .i_rd_event(hit(i_cmd, take, tgt_op_event, op_read)),
        .i_clr_event(clr_all),
        .o_parts(oper_parts),
        .o_sum(oper_sum)
    );

    // questionable register; its summary lands in status byte bit 3
    scpi_status_reg u_ques (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_cond(i_ques_cond),
        .i_wr_rise(hit(i_cmd, take, tgt_qu_rise, op_write)),
        .i_wr_fall(hit(i_cmd, take, tgt_qu_fall, op_write)),
        .i_wr_enable(hit(i_cmd, take, tgt_qu_enable, op_write)),
        .i_wdata(i_cmd.data),
        .i_rd_event(hit(i_cmd, take, tgt_qu_event, op_read)),
        .i_clr_event(clr_all),
        .o_parts(ques_parts),
        .o_sum(ques_sum)
    );

    // top of the tree: summaries feed the byte's condition bits
    status_byte_unit u_sbyte (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_err_not_empty(i_err_not_empty),
        .i_err_entry(i_err_entry),
        .i_ques_sum(ques_sum),
        .i_mav(i_msg_avail),
        .i_esb(esb),
        .i_oper_sum(oper_sum),
        .i_srmask(service_request_mask),
        .o_sbyte(o_sbyte),
        .o_srq(o_srq)
    );

    // read selection; spare targets answer zero, reads of the event parts
    // return the value held before the clear
    assign rd_data =
        (i_cmd.target == tgt_sbyte) ? {8'h00, o_sbyte} :
        (i_cmd.target == tgt_srmask) ? {8'h00, service_request_mask} :
        (i_cmd.target == tgt_esr) ? {8'h00, std_event_part} :
        (i_cmd.target == tgt_ese) ? {8'h00, std_enable_mask} :
        (i_cmd.target == tgt_op_cond) ? oper_parts.condition_part :
        (i_cmd.target == tgt_op_rise) ? oper_parts.rise_filter_part :
        (i_cmd.target == tgt_op_fall) ? oper_parts.fall_filter_part :
        (i_cmd.target == tgt_op_event) ? oper_parts.event_part :
        (i_cmd.target == tgt_op_enable) ? oper_parts.enable_part :
        (i_cmd.target == tgt_qu_cond) ? ques_parts.condition_part :
        (i_cmd.target == tgt_qu_rise) ? ques_parts.rise_filter_part :
        (i_cmd.target == tgt_qu_fall) ? ques_parts.fall_filter_part :
        (i_cmd.target == tgt_qu_event) ? ques_parts.event_part :
        (i_cmd.target == tgt_qu_enable) ? ques_parts.enable_part :
        16'h0000;

    // serial poll and status byte query give the same byte
    assign next_rsp.valid = i_serial_poll | (take && (i_cmd.op == op_read));
    assign next_rsp.data = i_serial_poll ? {8'h00, o_sbyte} : rd_data;

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_rsp <= '0;
        end else begin
            o_rsp <= next_rsp;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_srmask_write;
        wr_srmask ##1 (hit(i_cmd, take, tgt_srmask, op_read) && !wr_srmask);
    endsequence

    a_poll_answer: assert property (i_serial_poll |=>
        (o_rsp.valid && o_rsp.data == {8'h00, $past(o_sbyte)}))
        else $error("serial poll answer wrong");
    a_sbyte_query: assert property (hit(i_cmd, take, tgt_sbyte, op_read) |=>
        (o_rsp.valid && o_rsp.data[7:0] == $past(o_sbyte)))
        else $error("status byte query wrong");
    a_srmask_readback: assert property (s_srmask_write |=>
        (o_rsp.data == {8'h00, $past(i_cmd.data[7:0], 2)}))
        else $error("request mask readback wrong");
    a_esr_clear: assert property ((rd_esr && i_std_event == 8'h00) |=>
        (std_event_part == 8'h00)) else $error("standard events not cleared");
    a_esb_source: assert property (((i_std_event & std_enable_mask) != 8'h00 && !wr_ese)
        |=> ##1 o_sbyte[`SBYTE_ESB]) else $error("standard summary missing");
    a_oper_to_byte: assert property (oper_sum |=> o_sbyte[`SBYTE_OPER])
        else $error("operation summary not in byte");
    a_ques_to_byte: assert property (ques_sum |=> o_sbyte[`SBYTE_QUES])
        else $error("questionable summary not in byte");
    a_rsp_msb_zero: assert property (
        (o_rsp.valid && $past(take && i_cmd.target >= tgt_op_cond)) |-> !o_rsp.data[`PART_MSB])
        else $error("part bit 15 read as one");
endmodule

// file: scpi_status_defs.svh
`ifndef SCPI_STATUS_DEFS_SVH
`define SCPI_STATUS_DEFS_SVH
// How it works
// - each status register has five 16-bit parts sharing one bit position per source
// - bit 15 of every part always reads as zero
// - condition follows hardware or lower summary; read-only, never cleared
// - a 0-to-1 condition change sets the event bit if rise filter bit set
// - a 1-to-0 condition change sets the event bit if fall filter bit set
// - rise and fall filters are read/write; reads leave them unchanged
// - event part latches filtered transitions; read returns it then clears it
// - summary bit is the OR of event bits ANDed with enable bits
// - enable part is read/write at any time; reads leave it unchanged
// - each summary bit drives an assigned condition bit one level higher
// - request mask enables the status byte; standard mask enables standard events
// - status byte bit 6 summarises the other bits ANDed with the request mask
// - status byte query and serial poll both return the current status byte
// - a request rises when an enabled status byte bit goes 0 to 1
// - request mask is written by set command and returned by its query
// - bit 2 set on each error queue entry; enabled, each entry requests service
// - bit 3 carries the questionable register summary
// - bit 4 is set while a message waits in the output queue
// - bit 5 carries the standard event summary
// - bit 7 carries the operation register summary
// - standard summary set when an enabled standard event bit rises
`define PART_MSB 15
`define RISE_RESET 16'h7fff
`define FALL_RESET 16'h0000
`define ENABLE_RESET 16'h0000
`define EVENT_RESET 16'h0000
`define SRMASK_RESET 8'h00
`define ESE_RESET 8'h00
`define SBYTE_RESET 8'h00
`define SBYTE_ERRQ 2
`define SBYTE_QUES 3
`define SBYTE_MAV 4
`define SBYTE_ESB 5
`define SBYTE_MSS 6
`define SBYTE_OPER 7
`define SBYTE_REQ_MASK 8'hbc
`endif

// file: scpi_status_pkg.sv
package scpi_status_pkg;
    typedef enum logic [1:0] {
        op_read = 2'h0,
        op_write = 2'h1,
        op_clear = 2'h3
    } op_t;
    typedef enum logic [3:0] {
        tgt_sbyte = 4'h0,
        tgt_srmask = 4'h1,
        tgt_esr = 4'h2,
        tgt_ese = 4'h3,
        tgt_op_cond = 4'h4,
        tgt_op_rise = 4'h5,
        tgt_op_fall = 4'h6,
        tgt_op_event = 4'h7,
        tgt_op_enable = 4'h8,
        tgt_qu_cond = 4'h9,
        tgt_qu_rise = 4'ha,
        tgt_qu_fall = 4'hb,
        tgt_qu_event = 4'hc,
        tgt_qu_enable = 4'hd
    } target_t;
    typedef struct packed {
        logic valid;
        op_t op;
        target_t target;
        logic [15:0] data;
    } cmd_t;
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } rsp_t;
    typedef struct packed {
        logic [15:0] condition_part;
        logic [15:0] rise_filter_part;
        logic [15:0] fall_filter_part;
        logic [15:0] event_part;
        logic [15:0] enable_part;
    } parts_t;
    // forces the sign bit of a 16-bit part to zero
    function automatic logic [15:0] clip15(input logic [15:0] v);
        return {1'b0, v[14:0]};
    endfunction
endpackage

// file: scpi_status_reg.sv
`include "scpi_status_defs.svh"
module scpi_status_reg
    import scpi_status_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [15:0] i_cond,
    input wire logic i_wr_rise,
    input wire logic i_wr_fall,
    input wire logic i_wr_enable,
    input wire logic [15:0] i_wdata,
    input wire logic i_rd_event,
    input wire logic i_clr_event,
    output parts_t o_parts,
    output logic o_sum
);
    logic [15:0] condition_part;
    logic [15:0] rise_filter_part;
    logic [15:0] fall_filter_part;
    logic [15:0] event_part;
    logic [15:0] enable_part;
    wire logic [15:0] cond_now;
    wire logic [15:0] rises;
    wire logic [15:0] falls;
    wire logic [15:0] latched;
    wire logic [15:0] next_event;

    // edges against the previous sample; sign bit forced low at the source
    assign cond_now = clip15(i_cond);
    assign rises = cond_now & ~condition_part & rise_filter_part;
    assign falls = ~cond_now & condition_part & fall_filter_part;
    assign latched = rises | falls;
    // a transition in the read cycle survives the clear
    assign next_event = (i_rd_event | i_clr_event) ? latched : (event_part | latched);
    assign o_sum = |(event_part & enable_part);
    assign o_parts = '{condition_part, rise_filter_part, fall_filter_part,
                       event_part, enable_part};

    // condition has no write path at all, so it cannot be cleared
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            condition_part <= 16'h0000;
            rise_filter_part <= `RISE_RESET;
            fall_filter_part <= `FALL_RESET;
            event_part <= `EVENT_RESET;
            enable_part <= `ENABLE_RESET;
        end else begin
            condition_part <= cond_now;
            event_part <= next_event;
            if (i_wr_rise) rise_filter_part <= clip15(i_wdata);
            if (i_wr_fall) fall_filter_part <= clip15(i_wdata);
            if (i_wr_enable) enable_part <= clip15(i_wdata);
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    // the enable must not be rewritten in the cycle that latches the event
    sequence s_enabled_event;
        (((latched & enable_part) != 16'h0000) && !i_wr_enable) ##1 1'b1;
    endsequence

    a_rise_latch: assert property ((rises != 16'h0000) |=>
        ((event_part & $past(rises)) == $past(rises))) else $error("rise not latched");
    a_fall_latch: assert property ((falls != 16'h0000) |=>
        ((event_part & $past(falls)) == $past(falls))) else $error("fall not latched");
    a_only_filtered: assert property (
        ((event_part & ~$past(event_part) & ~$past(latched)) == 16'h0000))
        else $error("unfiltered event set");
    a_read_clears: assert property (i_rd_event |=>
        (event_part == $past(latched))) else $error("event read did not clear");
    a_msb_zero: assert property (!condition_part[`PART_MSB] && !event_part[`PART_MSB]
        && !rise_filter_part[`PART_MSB] && !fall_filter_part[`PART_MSB]
        && !enable_part[`PART_MSB])
        else $error("bit 15 set");
    a_sum_follows: assert property (s_enabled_event |-> o_sum)
        else $error("summary missing");
    a_filter_hold: assert property (!i_wr_rise && !i_wr_fall |=>
        $stable(rise_filter_part) && $stable(fall_filter_part))
        else $error("filter changed");
endmodule

// file: status_byte_unit.sv
`include "scpi_status_defs.svh"
module status_byte_unit
    import scpi_status_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_err_not_empty,
    input wire logic i_err_entry,
    input wire logic i_ques_sum,
    input wire logic i_mav,
    input wire logic i_esb,
    input wire logic i_oper_sum,
    input wire logic [7:0] i_srmask,
    output logic [7:0] o_sbyte,
    output logic o_srq
);
    wire logic [7:0] byte_src;
    wire logic [7:0] armed;
    wire logic mss;
    wire logic [7:0] next_sbyte;
    wire logic next_srq;

    // bits 0, 1 and 6 of the source are tied low; mask drops them too
    assign byte_src = {i_oper_sum, 1'b0, i_esb, i_mav, i_ques_sum,
                       i_err_not_empty | i_err_entry, 2'b00};
    assign armed = byte_src & i_srmask & `SBYTE_REQ_MASK;
    assign mss = |armed;
    assign next_sbyte = {byte_src[7], mss, byte_src[5:0]};
    // edge against the held byte, plus one request per queue entry
    assign next_srq = (|(armed & ~o_sbyte)) |
                      (i_err_entry & i_srmask[`SBYTE_ERRQ]);

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_sbyte <= `SBYTE_RESET;
            o_srq <= 1'b0;
        end else begin
            o_sbyte <= next_sbyte;
            o_srq <= next_srq;
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    a_mss_summary: assert property ((i_mav && i_srmask[`SBYTE_MAV]) |=>
        o_sbyte[`SBYTE_MSS]) else $error("mss not set");
    a_srq_on_rise: assert property (
        (i_mav && !o_sbyte[`SBYTE_MAV] && i_srmask[`SBYTE_MAV]) |=> o_srq)
        else $error("no request on rise");
    a_srq_bit6: assert property ((i_srmask == 8'h40) |=> !o_srq)
        else $error("mask bit 6 used");
    a_unused_zero: assert property ((o_sbyte[1:0] == 2'b00) &&
        (($past(i_srmask) != 8'h03) || !o_srq)) else $error("unused bits active");
    a_err_entry: assert property ((i_err_entry && i_srmask[`SBYTE_ERRQ]) |=>
        (o_srq && o_sbyte[`SBYTE_ERRQ])) else $error("queue entry missed");
endmodule

// file: remote_ctrl_model.sv
module remote_ctrl_model
    import scpi_status_pkg::*;
(
    input wire logic i_sys_clk,
    input wire rsp_t i_rsp,
    output cmd_t o_cmd,
    output logic o_serial_poll
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle command port from time zero
    initial begin
        o_cmd = '0;
        o_serial_poll = 1'b0;
    end

    // the answer stands only from the taking edge to the next one, so look just
    // after the edge on which the caller returned before waiting for another
    task automatic get_rsp(output logic [15:0] d);
        int n;
        d = 16'hdead;
        for (n = 0; n < 4; n++) begin
            #1;
            if (i_rsp.valid === 1'b1) begin
                d = i_rsp.data;
                break;
            end
            @(posedge i_sys_clk);
        end
    endtask

    // a request is held for exactly one edge, then the port goes idle
    task automatic issue(input op_t op, input target_t t, input logic [15:0] d);
        @(posedge i_sys_clk);
        o_cmd <= {1'b1, op, t, d};
        @(posedge i_sys_clk);
        o_cmd <= '0;
    endtask

    task automatic write_reg(input target_t t, input logic [15:0] d);
        issue(op_write, t, d);
    endtask

    task automatic read_reg(input target_t t, output logic [15:0] d);
        issue(op_read, t, 16'h0000);
        get_rsp(d);
    endtask

    // polling answers on the same response port as a query
    task automatic serial_poll(output logic [15:0] d);
        @(posedge i_sys_clk);
        o_serial_poll <= 1'b1;
        @(posedge i_sys_clk);
        o_serial_poll <= 1'b0;
        get_rsp(d);
    endtask
endmodule

// file: tb_scpi_status_reporting.sv
module tb_scpi_status_reporting
    import scpi_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(got, exp) check_val(16'(got), 16'(exp))
    typedef struct {target_t tgt; logic [15:0] wr; logic [15:0] exp;} row_t;
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    cmd_t i_cmd;
    logic i_serial_poll;
    logic [15:0] oper_cond = 16'h0000;
    logic [15:0] ques_cond = 16'h0000;
    logic [7:0] std_event = 8'h00;
    logic err_not_empty = 1'b0;
    logic err_entry = 1'b0;
    logic msg_avail = 1'b0;
    rsp_t o_rsp;
    logic [7:0] o_sbyte;
    logic o_srq;
    int num_errors = 0;
    int n_compared = 0;
    int srq_seen = 0;
    int s0;
    logic [15:0] d;
    logic [15:0] d2;
    row_t rows[10] = '{
        '{tgt_op_rise, 16'hffff, 16'h7fff}, '{tgt_op_fall, 16'h8000, 16'h0000},
        '{tgt_op_enable, 16'h1234, 16'h1234}, '{tgt_qu_rise, 16'h0f0f, 16'h0f0f},
        '{tgt_qu_fall, 16'ha5a5, 16'h25a5}, '{tgt_qu_enable, 16'h7fff, 16'h7fff},
        '{tgt_srmask, 16'h00ff, 16'h00ff}, '{tgt_ese, 16'h01a5, 16'h00a5},
        '{tgt_sbyte, 16'h00ff, 16'h0000}, '{tgt_op_cond, 16'h0fff, 16'h0000}};

    always #50 i_sys_clk = ~i_sys_clk;
    // the request is a one-cycle pulse, so count it at every edge
    always @(posedge i_sys_clk) if (o_srq === 1'b1) srq_seen++;

    scpi_status_reporting DUT (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_cmd(i_cmd),
        .i_serial_poll(i_serial_poll), .i_oper_cond(oper_cond), .i_ques_cond(ques_cond),
        .i_std_event(std_event), .i_err_not_empty(err_not_empty), .i_err_entry(err_entry),
        .i_msg_avail(msg_avail), .o_rsp(o_rsp), .o_sbyte(o_sbyte), .o_srq(o_srq));
    remote_ctrl_model ctrl (.i_sys_clk(i_sys_clk), .i_rsp(o_rsp), .o_cmd(i_cmd),
        .o_serial_poll(i_serial_poll));

    task automatic check_val(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic reset_dut();
        @(posedge i_sys_clk);
        i_nrst <= 1'b0;
        repeat (10) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
    endtask

    // a hung handshake ends the run through the same exit
    initial begin
        #500000;
        num_errors++;
        complete_run();
    end

    initial begin
        reset_dut();
        foreach (rows[i]) begin
            ctrl.write_reg(rows[i].tgt, rows[i].wr);
            ctrl.read_reg(rows[i].tgt, d);
            `CHK(d, rows[i].exp);
        end
        $display("test register table done");
        // second reset mid-run must restore the byte, the operation rise filter, the questionable fall filter and the request mask
        reset_dut();
        wait_cycles(1);
        `CHK(o_sbyte, 8'h00);
        ctrl.read_reg(tgt_op_rise, d);
        `CHK(d, 16'h7fff);
        ctrl.read_reg(tgt_qu_fall, d);
        `CHK(d, 16'h0000);
        ctrl.read_reg(tgt_srmask, d);
        `CHK(d, 16'h0000);
        $display("test reset values done");
        // operation rise climbs to the top byte and requests service
        ctrl.write_reg(tgt_op_enable, 16'h0008);
        ctrl.write_reg(tgt_srmask, 16'h0080);
        s0 = srq_seen;
        @(posedge i_sys_clk);
        oper_cond <= 16'h0008;
        wait_cycles(5);
        `CHK(srq_seen - s0, 1);
        `CHK(o_sbyte, 8'hc0);
        ctrl.read_reg(tgt_op_cond, d);
        `CHK(d, 16'h0008);
        ctrl.read_reg(tgt_op_event, d);
        `CHK(d, 16'h0008);
        ctrl.read_reg(tgt_op_event, d);
        `CHK(d, 16'h0000);
        wait_cycles(3);
        `CHK(o_sbyte, 8'h00);
        $display("test operation chain done");
        // falling edges only pass the fall filter
        ctrl.write_reg(tgt_op_rise, 16'h0000);
        ctrl.write_reg(tgt_op_fall, 16'h0008);
        @(posedge i_sys_clk);
        oper_cond <= 16'h0000;
        wait_cycles(3);
        ctrl.read_reg(tgt_op_event, d);
        `CHK(d, 16'h0008);
        @(posedge i_sys_clk);
        oper_cond <= 16'h0008;
        wait_cycles(3);
        ctrl.read_reg(tgt_op_event, d);
        `CHK(d, 16'h0000);
        $display("test transition filters done");
        // questionable summary, bit 15 of the live input dropped
        ctrl.write_reg(tgt_qu_enable, 16'h0004);
        ctrl.write_reg(tgt_srmask, 16'h0008);
        @(posedge i_sys_clk);
        ques_cond <= 16'h8004;
        wait_cycles(5);
        `CHK(o_sbyte, 8'h48);
        ctrl.read_reg(tgt_qu_cond, d);
        `CHK(d, 16'h0004);
        $display("test questionable done");
        // mask bit 6 alone must never request service
        ctrl.write_reg(tgt_srmask, 16'h0040);
        s0 = srq_seen;
        @(posedge i_sys_clk);
        msg_avail <= 1'b1;
        wait_cycles(4);
        `CHK(o_sbyte, 8'h18);
        `CHK(srq_seen - s0, 0);
        $display("test message and mask done");
        // each error entry gives its own request
        ctrl.write_reg(tgt_srmask, 16'h0004);
        s0 = srq_seen;
        repeat (2) begin
            @(posedge i_sys_clk);
            err_entry <= 1'b1;
            err_not_empty <= 1'b1;
            @(posedge i_sys_clk);
            err_entry <= 1'b0;
            wait_cycles(3);
        end
        `CHK(srq_seen - s0, 2);
        `CHK(o_sbyte, 8'h5c);
        $display("test error queue done");
        // standard event through its own enable mask
        ctrl.write_reg(tgt_ese, 16'h0001);
        ctrl.write_reg(tgt_srmask, 16'h0020);
        s0 = srq_seen;
        @(posedge i_sys_clk);
        std_event <= 8'h01;
        @(posedge i_sys_clk);
        std_event <= 8'h00;
        wait_cycles(4);
        `CHK(o_sbyte, 8'h7c);
        `CHK(srq_seen - s0, 1);
        ctrl.read_reg(tgt_esr, d);
        `CHK(d, 16'h0001);
        $display("test standard events done");
        // query and poll must agree with each other and with the pins
        wait_cycles(3);
        ctrl.read_reg(tgt_sbyte, d);
        ctrl.serial_poll(d2);
        `CHK(d, 16'h001c);
        `CHK(d2, 16'h001c);
        `CHK(o_sbyte, 8'h1c);
        $display("test status byte read done");
        // a clear command empties every event part, whatever its target
        @(posedge i_sys_clk);
        std_event <= 8'h01;
        @(posedge i_sys_clk);
        std_event <= 8'h00;
        ctrl.issue(op_clear, tgt_sbyte, 16'h0000);
        ctrl.read_reg(tgt_esr, d);
        `CHK(d, 16'h0000);
        ctrl.read_reg(tgt_qu_event, d);
        `CHK(d, 16'h0000);
        wait_cycles(3);
        `CHK(o_sbyte, 8'h14);
        $display("test clear command done");
        complete_run();
    end
endmodule
